// file: rtc_supply_trim.sv
// supply supervision, battery flags and digital rate trim of the rtc core
// assumes comparator levels and oscillator phase synchronous to i_mclk
// Contract
// - full-charge flag is read-only and refreshed once per second outside backup.
// - low-battery flag is sticky; writing 0 clears, writing 1 is ignored.
// - detect enable 0 follows charge enable; enable 1 detects on main supply.
// - no low-battery detection in backup; flagged after main supply returns.
// - stop bit set suspends the 31.25 ms backup supply sampling.
// - reset output low while supply below selected trip level.
// - with init bit set, bus and clock output stop below trip level.
// - threshold select bit picks 2.75 V (0) or 2.70 V (1).
// - reset-detect flag latches on a drop; write 0 clears it.
// - trim enable turns correction on; when 0 the code is ignored.
// - correction applied to sub-second counting once every ten seconds.
// - each code unit changes the rate by 3.05 ppm.
// - code is seven-bit two's complement, top bit the sign.
// - 32.768 kHz output untouched; 1 Hz and 1024 Hz disturbed per 10 s.
// - wakeup source 64 Hz or 1 Hz disturbed; 4096 Hz untouched.
// - alarm second tick follows the corrected time base.
// - sampling field sets switch-off time 2, 16, 128 or 256 ms.
// - full-charge select picks level or no limit.
// - power switching starts at first init write and then stays on.
`timescale 1ns/10ps
module rtc_supply_trim
  import rtc_trim_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              i_osc_phase,
  input  wire supply_levels_t    i_levels,
  input  wire clk_out_sel_t      i_clk_out_sel,
  input  wire wake_src_t         i_wake_src,
  output logic                   o_reset_n,
  output logic                   o_iface_enable,
  output logic                   o_backup_mode,
  output logic                   o_backup_sample,
  output logic                   o_sw1_open,
  output logic                   o_clk_out,
  output logic                   o_sec_tick,
  output logic                   o_wake_tick
);

  logic [7:0]         ctrl1_r, ctrl1_nxt, ctrl2_r, ctrl2_nxt;
  logic [7:0]         trim_r, trim_nxt;
  logic               low_r, low_nxt, rst_flag_r, rst_flag_nxt;
  logic               full_r, full_nxt, switch_on_r, switch_on_nxt;
  logic               backup_r, backup_nxt, reset_n_r, reset_n_nxt;
  logic               iface_r, iface_nxt, sw1_r, sw1_nxt;
  logic               bsamp_r, bsamp_nxt;
  logic [10:0]        bcnt_r, bcnt_nxt;
  logic [13:0]        off_r, off_nxt;
  logic [31:0]        prdata_r, prdata_nxt;
  logic               pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic               phase_r;
  logic [PRESC_W-1:0] presc_r, presc_nxt;
  logic [2:0]         fast_r, fast_nxt;
  logic [3:0]         sec_r, sec_nxt;
  logic               due_r, due_nxt;
  logic               sec_tick_r, sec_tick_nxt, wake_r, wake_nxt;
  logic               clk_out_r, clk_out_nxt;
  logic               osc_tick, sec_evt, below_trip, detect_ok;
  logic               wr, wr_flags, wr_ctrl1, wr_ctrl2, wr_trim;
  logic [1:0]         bf_sel;
  logic [13:0]        off_ticks;

  assign osc_tick   = i_osc_phase & ~phase_r;
  assign sec_evt    = osc_tick & (&presc_r);
  assign below_trip = ctrl1_r[C1_RSEL] ? i_levels.below_trip_lo
                                       : i_levels.below_trip_hi;
  assign wr       = psel & penable & pready_r & pwrite;
  assign wr_flags = wr & (paddr == ADDR_FLAGS);
  assign wr_ctrl1 = wr & (paddr == ADDR_CTRL1);
  assign wr_ctrl2 = wr & (paddr == ADDR_CTRL2);
  assign wr_trim  = wr & (paddr == ADDR_TRIM);
  assign bf_sel   = {ctrl1_r[C1_BF_HI], ctrl1_r[C1_BF_LO]};
  assign detect_ok = ~backup_r &
                     (ctrl2_r[C2_LBE] | ctrl1_r[C1_CHG]);

  always_comb begin
    unique case ({ctrl1_r[C1_SMP_HI], ctrl1_r[C1_SMP_LO]})
      2'h0: off_ticks = 14'(OFF_TICKS_0);
      2'h1: off_ticks = 14'(OFF_TICKS_1);
      2'h2: off_ticks = 14'(OFF_TICKS_2);
      2'h3: off_ticks = 14'(OFF_TICKS_3);
    endcase
  end

  // bus answer: one wait cycle, then pready with read data
  always_comb begin
    pready_nxt  = psel & penable & ~pready_r;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    if (pready_nxt) begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        ADDR_FLAGS: begin
          prdata_nxt[FLG_LOW]  = low_r;
          prdata_nxt[FLG_RST]  = rst_flag_r;
          prdata_nxt[FLG_FULL] = full_r;
        end
        ADDR_CTRL1: prdata_nxt[7:0] = ctrl1_r;
        ADDR_CTRL2: prdata_nxt[7:0] = ctrl2_r;
        ADDR_TRIM:  prdata_nxt[7:0] = trim_r;
        default:    pslverr_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // registers, flags and supply state
  always_comb begin
    ctrl1_nxt = wr_ctrl1 ? (pwdata[7:0] & CTRL1_WMASK) : ctrl1_r;
    ctrl2_nxt = wr_ctrl2 ? (pwdata[7:0] & CTRL2_WMASK) : ctrl2_r;
    trim_nxt  = wr_trim ? pwdata[7:0] : trim_r;
    switch_on_nxt = switch_on_r | (wr_ctrl1 & pwdata[C1_INIT]);
    low_nxt = low_r;
    if (wr_flags && !pwdata[FLG_LOW])
      low_nxt = 1'b0;
    if (sec_evt && detect_ok && i_levels.vbat_low)
      low_nxt = 1'b1;
    rst_flag_nxt = rst_flag_r;
    if (wr_flags && !pwdata[FLG_RST])
      rst_flag_nxt = 1'b0;
    if (below_trip)
      rst_flag_nxt = 1'b1;
    full_nxt = full_r;
    if (sec_evt && !backup_r) begin
      full_nxt = (bf_sel == BF_NO_LIMIT) ? 1'b0
                                         : i_levels.vbat_full[bf_sel];
    end
    reset_n_nxt = ~below_trip;
    iface_nxt   = ~(ctrl1_r[C1_INIT] & below_trip);
    bcnt_nxt  = bcnt_r;
    bsamp_nxt = 1'b0;
    if (backup_r && !ctrl2_r[C2_STOP] && osc_tick) begin
      if (bcnt_r == 11'(BKP_SAMPLE_TICKS - 1)) begin
        bcnt_nxt  = 11'h000;
        bsamp_nxt = 1'b1;
      end else begin
        bcnt_nxt = bcnt_r + 11'h001;
      end
    end
    if (!backup_r)
      bcnt_nxt = 11'h000;
    backup_nxt = backup_r;
    if (!backup_r)
      backup_nxt = switch_on_r & i_levels.below_backup;
    else if (bsamp_r && !i_levels.below_backup)
      backup_nxt = 1'b0;
    off_nxt = off_r;
    if (backup_r || !ctrl1_r[C1_CHG] || full_r)
      off_nxt = 14'h0000;
    else if (sec_evt)
      off_nxt = off_ticks;
    else if (osc_tick && off_r != 14'h0000)
      off_nxt = off_r - 14'h0001;
    sw1_nxt = off_r != 14'h0000;
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ctrl1_r     <= CTRL1_RST;
      ctrl2_r     <= CTRL2_RST;
      trim_r      <= TRIM_RST;
      switch_on_r <= 1'b0;
      low_r       <= 1'b0;
      rst_flag_r  <= 1'b0;
      full_r      <= 1'b0;
      reset_n_r   <= 1'b0;
      iface_r     <= 1'b0;
      bcnt_r      <= 11'h000;
      bsamp_r     <= 1'b0;
      backup_r    <= 1'b0;
      off_r       <= 14'h0000;
      sw1_r       <= 1'b0;
    end else begin
      ctrl1_r     <= ctrl1_nxt;
      ctrl2_r     <= ctrl2_nxt;
      trim_r      <= trim_nxt;
      switch_on_r <= switch_on_nxt;
      low_r       <= low_nxt;
      rst_flag_r  <= rst_flag_nxt;
      full_r      <= full_nxt;
      reset_n_r   <= reset_n_nxt;
      iface_r     <= iface_nxt;
      bcnt_r      <= bcnt_nxt;
      bsamp_r     <= bsamp_nxt;
      backup_r    <= backup_nxt;
      off_r       <= off_nxt;
      sw1_r       <= sw1_nxt;
    end
  end

  // time base with rate trim
  always_comb begin
    presc_nxt = presc_r;
    fast_nxt  = fast_r;
    sec_nxt   = sec_r;
    due_nxt   = due_r & trim_r[TRIM_EN];
    if (osc_tick) begin
      fast_nxt = fast_r + 3'h1;
      if (due_r && trim_r[TRIM_EN] && presc_r == TRIM_POINT) begin
        presc_nxt = presc_r + 15'h0001
                    + {{8{trim_r[6]}}, trim_r[6:0]};
        due_nxt = 1'b0;
      end else begin
        presc_nxt = presc_r + 15'h0001;
      end
      if (&presc_r) begin
        if (sec_r == 4'(TRIM_INTERVAL_S - 1)) begin
          sec_nxt = 4'h0;
          due_nxt = trim_r[TRIM_EN];
        end else begin
          sec_nxt = sec_r + 4'h1;
        end
      end
    end
    sec_tick_nxt = sec_evt;
    unique case (i_wake_src)
      WAKE_4096: wake_nxt = osc_tick & (&fast_r);
      WAKE_64:   wake_nxt = osc_tick & (&presc_r[TAP_64:0]);
      WAKE_1HZ:  wake_nxt = sec_evt;
      default:   wake_nxt = 1'b0;
    endcase
    unique case (i_clk_out_sel)
      OUT_32K:  clk_out_nxt = i_osc_phase;
      OUT_1024: clk_out_nxt = presc_r[TAP_1024];
      OUT_1HZ:  clk_out_nxt = presc_r[TAP_1HZ];
      default:  clk_out_nxt = 1'b0;
    endcase
    clk_out_nxt = clk_out_nxt & iface_r;
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      phase_r    <= 1'b0;
      presc_r    <= '0;
      fast_r     <= 3'h0;
      sec_r      <= 4'h0;
      due_r      <= 1'b0;
      sec_tick_r <= 1'b0;
      wake_r     <= 1'b0;
      clk_out_r  <= 1'b0;
    end else begin
      phase_r    <= i_osc_phase;
      presc_r    <= presc_nxt;
      fast_r     <= fast_nxt;
      sec_r      <= sec_nxt;
      due_r      <= due_nxt;
      sec_tick_r <= sec_tick_nxt;
      wake_r     <= wake_nxt;
      clk_out_r  <= clk_out_nxt;
    end
  end

  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign o_reset_n       = reset_n_r;
  assign o_iface_enable  = iface_r;
  assign o_backup_mode   = backup_r;
  assign o_backup_sample = bsamp_r;
  assign o_sw1_open      = sw1_r;
  assign o_clk_out       = clk_out_r;
  assign o_sec_tick      = sec_tick_r;
  assign o_wake_tick     = wake_r;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  sequence s_trim_step;
    osc_tick && due_r && trim_r[TRIM_EN] && presc_r == TRIM_POINT;
  endsequence

  property p_reset_out;
    below_trip |=> !o_reset_n ##0 rst_flag_r;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("reset output or flag missed a drop");

  property p_iface_stop;
    ctrl1_r[C1_INIT] && below_trip |=> !o_iface_enable ##1 !o_clk_out;
  endproperty
  a_iface_stop: assert property (p_iface_stop)
    else $error("interface not stopped below trip");

  property p_low_sticky;
    low_r && !wr_flags |=> low_r;
  endproperty
  a_low_sticky: assert property (p_low_sticky)
    else $error("low battery flag dropped");

  property p_no_low_backup;
    backup_r && !low_r |=> !low_r;
  endproperty
  a_no_low_backup: assert property (p_no_low_backup)
    else $error("low battery set in backup");

  property p_stop_hold;
    backup_r && ctrl2_r[C2_STOP] |=> !bsamp_r ##0 $stable(bcnt_r);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("backup sampling ran with stop set");

  property p_trim_off;
    osc_tick && !trim_r[TRIM_EN] |=> presc_r == $past(presc_r) + 15'h0001;
  endproperty
  a_trim_off: assert property (p_trim_off)
    else $error("divider jumped with trim disabled");

  property p_trim_apply;
    s_trim_step |=> !due_r ##0
      presc_r == $past(presc_r) + 15'h0001
                 + {{8{$past(trim_r[6])}}, $past(trim_r[6:0])};
  endproperty
  a_trim_apply: assert property (p_trim_apply)
    else $error("trim step wrong");

  property p_full_hold;
    !sec_evt |=> $stable(full_r);
  endproperty
  a_full_hold: assert property (p_full_hold)
    else $error("full flag changed off the second");

  property p_switch_sticky;
    switch_on_r |=> switch_on_r;
  endproperty
  a_switch_sticky: assert property (p_switch_sticky)
    else $error("power switching stopped");

endmodule

// file: rtc_supply_trim_bench.sv
// scenario bench of the supply monitor and rate trim block
// assumes the supply_env model and the design package
`timescale 1ns/10ps
module rtc_supply_trim_bench
  import rtc_trim_pkg::*;
;
  logic              i_mclk = 1'b0;
  logic              i_reset = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              osc;
  supply_levels_t    want = '0;
  supply_levels_t    levels;
  clk_out_sel_t      osel = OUT_1024;
  wake_src_t         wsel = WAKE_64;
  logic              rst_n, ifc_en, bkp, bkp_smp, sw1, clk_o, sec, wake;
  int                num_errors = 0;
  int                check_count = 0;

  always #2 i_mclk = ~i_mclk;

  supply_env supply_env_i (.i_mclk(i_mclk), .i_want(want),
    .o_osc_phase(osc), .o_levels(levels));

  rtc_supply_trim rtc_supply_trim_i (.i_mclk(i_mclk), .i_reset(i_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_osc_phase(osc), .i_levels(levels),
    .i_clk_out_sel(osel), .i_wake_src(wsel), .o_reset_n(rst_n),
    .o_iface_enable(ifc_en), .o_backup_mode(bkp),
    .o_backup_sample(bkp_smp), .o_sw1_open(sw1), .o_clk_out(clk_o),
    .o_sec_tick(sec), .o_wake_tick(wake));

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [7:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge i_mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, wd};
    @(posedge i_mclk);
    penable <= 1'b1;
    do @(posedge i_mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
    check("write error", {31'h0000_0000, err}, 32'h0000_0000);
  endtask

  task automatic rdchk(input string name, input logic [ADDR_W-1:0] a,
                       input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 8'h00, rd, err);
    check(name, rd, exp);
    check("read error", {31'h0000_0000, err}, 32'h0000_0000);
  endtask

  task automatic lv(input supply_levels_t v);
    @(posedge i_mclk);
    want <= v;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic t_regs();
    logic [31:0] rd;
    logic        err;
    rdchk("flags rst", ADDR_FLAGS, 32'h0000_0000);
    rdchk("ctrl1 rst", ADDR_CTRL1, 32'h0000_0000);
    rdchk("ctrl2 rst", ADDR_CTRL2, 32'h0000_0000);
    rdchk("trim rst", ADDR_TRIM, 32'h0000_0000);
    wr(ADDR_CTRL1, 8'hff);
    rdchk("ctrl1 rw", ADDR_CTRL1, 32'h0000_00f7);
    wr(ADDR_TRIM, 8'hff);
    rdchk("trim rw", ADDR_TRIM, 32'h0000_00ff);
    wr(ADDR_TRIM, 8'h40);
    rdchk("trim code", ADDR_TRIM, 32'h0000_0040);
    wr(ADDR_CTRL2, 8'hff);
    rdchk("ctrl2 rw", ADDR_CTRL2, 32'h0000_0003);
    wr(ADDR_CTRL2, 8'h02);
    wr(ADDR_CTRL1, 8'h30);
    apb(1'b0, 10'h3fc, 8'h00, rd, err);
    check("unmapped data", rd, 32'h0000_0000);
    check("unmapped err", {31'h0000_0000, err}, 32'h0000_0001);
  endtask

  task automatic t_reset_out();
    cyc(5);
    check("iface up", {31'h0, ifc_en}, 32'h0000_0001);
    lv(7'b100_0000);
    cyc(5);
    check("rst low", {31'h0, rst_n}, 32'h0000_0000);
    check("iface stop", {31'h0, ifc_en}, 32'h0000_0000);
    check("clk out stop", {31'h0, clk_o}, 32'h0000_0000);
    lv(7'b000_0000);
    cyc(5);
    check("rst high", {31'h0, rst_n}, 32'h0000_0001);
    rdchk("rsf set", ADDR_FLAGS, 32'h0000_0004);
    wr(ADDR_FLAGS, 8'hff);
    rdchk("rsf w1", ADDR_FLAGS, 32'h0000_0004);
    wr(ADDR_FLAGS, 8'h00);
    rdchk("rsf w0", ADDR_FLAGS, 32'h0000_0000);
    wr(ADDR_CTRL1, 8'h34);
    lv(7'b100_0000);
    cyc(5);
    check("rst sel 2v70", {31'h0, rst_n}, 32'h0000_0001);
    lv(7'b110_0000);
    cyc(5);
    check("rst lo trip", {31'h0, rst_n}, 32'h0000_0000);
    lv(7'b000_0000);
    cyc(5);
    wr(ADDR_CTRL1, 8'h30);
    wr(ADDR_FLAGS, 8'h00);
  endtask

  task automatic wake_gap(input wake_src_t s, input int exp);
    int n;
    @(posedge i_mclk);
    wsel <= s;
    repeat (4) @(posedge i_mclk);
    do @(posedge i_mclk); while (wake !== 1'b1);
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (wake !== 1'b1);
    check("wake gap", n, exp);
  endtask

  task automatic out_high(input clk_out_sel_t s);
    int k;
    @(posedge i_mclk);
    osel <= s;
    repeat (4) @(posedge i_mclk);
    k = 0;
    repeat (640) begin
      @(posedge i_mclk);
      if (clk_o === 1'b1) k++;
    end
    check("clk out duty", k, 320);
  endtask

  task automatic t_wake();
    wake_gap(WAKE_4096, 2 * OSC_HZ / 4096);
    wake_gap(WAKE_64, 2 * OSC_HZ / 64);
    out_high(OUT_32K);
    out_high(OUT_1024);
  endtask

  task automatic t_second();
    int n;
    int k;
    lv(7'b000_1000);
    n = 0;
    while (sec !== 1'b1 && n < 70000) begin
      @(posedge i_mclk);
      n++;
    end
    check("second seen", {31'h0, sec}, 32'h0000_0001);
    k = 0;
    repeat (300) begin
      @(posedge i_mclk);
      if (sw1 === 1'b1) k++;
    end
    check("sw1 window", k, 2 * OFF_TICKS_0);
    cyc(4);
    rdchk("full low", ADDR_FLAGS, 32'h0000_0080);
    wr(ADDR_FLAGS, 8'h7f);
    rdchk("low w0c", ADDR_FLAGS, 32'h0000_0000);
  endtask

  task automatic t_backup();
    int k;
    int n;
    wr(ADDR_CTRL2, 8'h03);
    lv(7'b001_0000);
    cyc(4);
    check("bkp in", {31'h0, bkp}, 32'h0000_0001);
    k = 0;
    repeat (2200) begin
      @(posedge i_mclk);
      if (bkp_smp === 1'b1) k++;
    end
    check("stop samples", k, 0);
    wr(ADDR_CTRL2, 8'h02);
    repeat (2200) begin
      @(posedge i_mclk);
      if (bkp_smp === 1'b1) k++;
    end
    check("run samples", {31'h0, k > 0}, 32'h0000_0001);
    lv(7'b000_0000);
    n = 0;
    while (bkp !== 1'b0 && n < 2200) begin
      @(posedge i_mclk);
      n++;
    end
    check("bkp out", {31'h0, bkp}, 32'h0000_0000);
  endtask

  initial begin
    repeat (95000) @(posedge i_mclk);
    num_errors++;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge i_mclk);
    i_reset <= 1'b0;
    t_regs();
    t_reset_out();
    t_wake();
    t_second();
    t_backup();
    end_sim();
  end
endmodule

// file: rtc_trim_pkg.sv
// constants, field layouts and carrier types of the supply monitor and trim
// assumes byte addresses on the register bus are four times the index
package rtc_trim_pkg;

  localparam logic [7:0] IDX_FLAGS = 8'h1d;
  localparam logic [7:0] IDX_CTRL1 = 8'h1f;
  localparam logic [7:0] IDX_CTRL2 = 8'h21;
  localparam logic [7:0] IDX_TRIM  = 8'h30;
  localparam int         ADDR_W    = 10;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = {IDX_FLAGS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CTRL1 = {IDX_CTRL1, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CTRL2 = {IDX_CTRL2, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TRIM  = {IDX_TRIM, 2'b00};

  localparam int FLG_LOW   = 7;
  localparam int FLG_RST   = 2;
  localparam int FLG_FULL  = 0;
  localparam int C1_SMP_HI = 7;
  localparam int C1_SMP_LO = 6;
  localparam int C1_CHG    = 5;
  localparam int C1_INIT   = 4;
  localparam int C1_RSEL   = 2;
  localparam int C1_BF_HI  = 1;
  localparam int C1_BF_LO  = 0;
  localparam int C2_STOP   = 0;
  localparam int C2_LBE    = 1;
  localparam int TRIM_EN   = 7;

  localparam logic [7:0] CTRL1_RST   = 8'h00;
  localparam logic [7:0] CTRL2_RST   = 8'h00;
  localparam logic [7:0] TRIM_RST    = 8'h00;
  localparam logic [7:0] CTRL1_WMASK = 8'hf7;
  localparam logic [7:0] CTRL2_WMASK = 8'h03;
  localparam logic [1:0] BF_NO_LIMIT = 2'h3;

  localparam int OSC_HZ          = 32768;
  localparam int BKP_SAMPLE_US   = 31250;
  localparam int BKP_SAMPLE_TICKS = BKP_SAMPLE_US * OSC_HZ / 1000000;
  localparam int TRIM_INTERVAL_S = 10;
  localparam int OFF_MS_0        = 2;
  localparam int OFF_MS_1        = 16;
  localparam int OFF_MS_2        = 128;
  localparam int OFF_MS_3        = 256;
  localparam int OFF_TICKS_0     = OFF_MS_0 * OSC_HZ / 1000;
  localparam int OFF_TICKS_1     = OFF_MS_1 * OSC_HZ / 1000;
  localparam int OFF_TICKS_2     = OFF_MS_2 * OSC_HZ / 1000;
  localparam int OFF_TICKS_3     = OFF_MS_3 * OSC_HZ / 1000;

  localparam int PRESC_W = 15;
  localparam logic [PRESC_W-1:0] TRIM_POINT = 15'h4000;
  localparam int TAP_1024 = 4;
  localparam int TAP_64   = 8;
  localparam int TAP_1HZ  = 14;

  typedef enum logic [1:0] {OUT_32K, OUT_1024, OUT_1HZ} clk_out_sel_t;
  typedef enum logic [1:0] {WAKE_4096, WAKE_64, WAKE_1HZ} wake_src_t;

  typedef struct packed {
    logic       below_trip_hi;
    logic       below_trip_lo;
    logic       below_backup;
    logic       vbat_low;
    logic [2:0] vbat_full;
  } supply_levels_t;

endpackage

// file: supply_env.sv
// oscillator and supply comparator source facing the supervision block
// assumes the bench sets wanted levels just after a rising edge
`timescale 1ns/10ps
module supply_env
  import rtc_trim_pkg::*;
(
  input  wire logic           i_mclk,
  input  wire supply_levels_t i_want,
  output logic                o_osc_phase,
  output supply_levels_t      o_levels
);
  initial o_osc_phase = 1'b0;
  initial o_levels = '0;
  // one oscillator tick every two clock cycles, levels one cycle late
  always @(posedge i_mclk) begin
    o_osc_phase <= ~o_osc_phase;
    o_levels    <= i_want;
  end
endmodule
